// ### shared/vic_pkg.sv
// shared constants for the 32-channel vectored interrupt controller
package vic_pkg;
  localparam int NUM_CHANNELS   = 32;                 // prioritized request channels
  localparam int CHANNEL_W      = 5;                  // width of a channel or source number
  localparam int UNIT_CHANNELS  = 16;                 // channels held by one standard unit
  localparam int NUM_PERIPH     = 27;                 // on-chip peripheral request inputs
  localparam int NUM_WAKE_REQ   = 5;                  // requests made by the wake-up unit
  localparam int NUM_WAKE_PINS  = 30;                 // external wake-up pin inputs
  localparam int GROUP_PINS     = 8;                  // pins in wake-up groups one to three
  localparam int GROUP0_PINS    = 6;                  // pins in wake-up group zero
  localparam int VECTOR_W       = 32;                 // vector address width

  // positions inside the registered wake-up request word
  localparam int WAKE_ALL       = 0;                  // or of all 32 wake-up inputs
  localparam int WAKE_GROUP0    = 1;                  // port-3 pins plus clock and resume
  localparam int WAKE_GROUP1    = 2;                  // port-5 pins
  localparam int WAKE_GROUP2    = 3;                  // port-6 pins
  localparam int WAKE_GROUP3    = 4;                  // port-7 pins

  // first pin of each group inside the wake-up pin bus
  localparam int GROUP0_BASE    = 0;
  localparam int GROUP1_BASE    = 6;
  localparam int GROUP2_BASE    = 14;
  localparam int GROUP3_BASE    = 22;

  localparam logic [VECTOR_W-1:0]  VECTOR_STRIDE = 32'h0000_0004; // bytes between vector slots
  localparam logic [CHANNEL_W-1:0] UNIT0_BASE    = 5'h00;         // first channel of the high unit
  localparam logic [CHANNEL_W-1:0] UNIT1_BASE    = 5'h10;         // first channel of the low unit
  localparam logic [CHANNEL_W-1:0] CHANNEL_NONE  = 5'h00;         // channel shown when nothing wins

  // recommended source channels, kept for integration only
  localparam int REC_WATCHDOG   = 0;
  localparam int REC_TIMER0     = 4;
  localparam int REC_DMA        = 12;
  localparam int REC_BUS_RESUME = 30;
endpackage : vic_pkg

// ### src/priority_unit.sv
// one standard 16-channel priority unit with a daisy-chain input
`timescale 1ns/10ps
`default_nettype none
module priority_unit
  import vic_pkg::*;
#(
  parameter logic [vic_pkg::CHANNEL_W-1:0] BASE = vic_pkg::UNIT0_BASE  // channel number of bit zero
) (
  input  wire logic [vic_pkg::UNIT_CHANNELS-1:0] request,        // active vectored channels of this unit
  input  wire logic                              chain_hit,      // a lower-priority unit has a winner
  input  wire logic [vic_pkg::CHANNEL_W-1:0]     chain_channel,  // that unit's winning channel
  output logic                                   hit,            // some channel wins here or below
  output logic [vic_pkg::CHANNEL_W-1:0]          channel         // winning channel number
);

  // scan from the lowest-priority bit up so the lowest number is written last and wins;
  // a local request always beats the chained one because this unit sits higher in the chain
  always_comb begin
    hit     = chain_hit;
    channel = chain_channel;
    for (int i = UNIT_CHANNELS - 1; i >= 0; i--) begin
      if (request[i]) begin
        hit     = 1'b1;
        channel = BASE + CHANNEL_W'(i);
      end
    end
  end

endmodule : priority_unit
`default_nettype wire

// ### src/vectored_interrupt_controller.sv
// 32-channel vectored interrupt controller built from two chained priority units
`timescale 1ns/10ps
`default_nettype none
module vectored_interrupt_controller
  import vic_pkg::*;
(
  input  wire logic                                       clock,          // 50 MHz bus clock
  input  wire logic                                       reset,          // synchronous, active high
  input  wire logic                                       enable,         // clock enable, freezes all state
  input  wire logic [vic_pkg::NUM_PERIPH-1:0]             peripheral_irq, // on-chip peripheral levels
  input  wire logic [vic_pkg::NUM_WAKE_PINS-1:0]          wake_pin,       // external wake-up pins, async
  input  wire logic [vic_pkg::NUM_WAKE_PINS-1:0]          wake_pin_enable,// per-pin wake-up enable
  input  wire logic                                       rtc_irq,        // real-time clock interrupt
  input  wire logic                                       usb_resume_irq, // bus resume interrupt
  input  wire logic [vic_pkg::NUM_CHANNELS*vic_pkg::CHANNEL_W-1:0] channel_map, // source per channel
  input  wire logic [vic_pkg::NUM_CHANNELS-1:0]           force_request,  // software forced requests
  input  wire logic [vic_pkg::NUM_CHANNELS-1:0]           fiq_select,     // channels routed to fast
  input  wire logic [vic_pkg::VECTOR_W-1:0]               vector_base,    // address of channel 0 vector
  input  wire logic [vic_pkg::VECTOR_W-1:0]               default_vector, // vector when nothing wins
  input  wire logic                                       vector_read,    // core reads the vector
  output logic                                            fast_interrupt_request, // fast request
  output logic                                            irq,            // vectored request
  output logic                                            vector_ready,   // read answer strobe
  output logic                                            vector_hit,     // a channel won the read
  output logic [vic_pkg::CHANNEL_W-1:0]                   vector_channel, // winning channel
  output logic [vic_pkg::CHANNEL_W-1:0]                   vector_source,  // source mapped to it
  output logic [vic_pkg::VECTOR_W-1:0]                    vector_addr     // vector address
);

  // pin synchroniser stages; the first stage feeds only the second
  logic [NUM_WAKE_PINS-1:0] wake_meta_q;     // first stage
  logic [NUM_WAKE_PINS-1:0] wake_sync_q;     // second stage, safe to use
  logic [NUM_WAKE_PINS-1:0] wake_pins_on;    // enabled, synchronised pins
  logic [NUM_WAKE_REQ-1:0]  wake_req_d;      // wake-up unit requests, next value
  logic [NUM_WAKE_REQ-1:0]  wake_req_q;      // wake-up unit requests, registered
  logic [NUM_CHANNELS-1:0]  sources;         // all 32 request sources
  logic [CHANNEL_W-1:0]     map_arr [NUM_CHANNELS]; // unpacked channel map
  logic [NUM_CHANNELS-1:0]  channel_req;     // per-channel request after map and force
  logic [NUM_CHANNELS-1:0]  pending_q;       // registered channel levels
  logic [NUM_CHANNELS-1:0]  irq_pending;     // pending channels on the vectored path
  logic [NUM_CHANNELS-1:0]  fiq_pending;     // pending channels on the fast path
  logic                     low_hit;         // winner in channels 16..31
  logic [CHANNEL_W-1:0]     low_channel;
  logic                     best_hit;        // overall winner exists
  logic [CHANNEL_W-1:0]     best_channel;    // overall winning channel
  logic                     fiq_q;
  logic                     irq_q;
  logic                     ready_q;
  logic                     hit_q;
  logic [CHANNEL_W-1:0]     channel_q;
  logic [CHANNEL_W-1:0]     source_q;
  logic [VECTOR_W-1:0]      addr_q;

  // two-flop synchroniser for the external pins; clock and resume come from on-chip logic
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_meta_q <= '0;
      wake_sync_q <= '0;
    end else if (enable) begin
      wake_meta_q <= wake_pin;
      wake_sync_q <= wake_meta_q;
    end
  end

  assign wake_pins_on = wake_sync_q & wake_pin_enable;

  // wake-up unit: one global or, group zero of six pins plus clock and resume, and three groups of eight
  always_comb begin
    wake_req_d              = '0;
    wake_req_d[WAKE_ALL]    = (|wake_pins_on) | rtc_irq | usb_resume_irq;
    wake_req_d[WAKE_GROUP0] = (|wake_pins_on[GROUP0_BASE +: GROUP0_PINS]) | rtc_irq | usb_resume_irq;
    wake_req_d[WAKE_GROUP1] = |wake_pins_on[GROUP1_BASE +: GROUP_PINS];
    wake_req_d[WAKE_GROUP2] = |wake_pins_on[GROUP2_BASE +: GROUP_PINS];
    wake_req_d[WAKE_GROUP3] = |wake_pins_on[GROUP3_BASE +: GROUP_PINS];
  end

  // registering the wake-up word keeps its or trees out of the mapping path
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_req_q <= '0;
    end else if (enable) begin
      wake_req_q <= wake_req_d;
    end
  end

  // source numbering: peripherals first, then the five wake-up requests
  assign sources = {wake_req_q, peripheral_irq};

  // per-channel source select plus software force
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHANNELS; gc++) begin : g_chan
      assign map_arr[gc]     = channel_map[gc*CHANNEL_W +: CHANNEL_W];
      assign channel_req[gc] = sources[map_arr[gc]]
                             | force_request[gc];
    end
  endgenerate

  // levels are sampled every cycle, so a request lasts exactly as long as its cause
  always_ff @(posedge clock) begin
    if (reset) begin
      pending_q <= '0;
    end else if (enable) begin
      pending_q <= channel_req;
    end
  end

  // a channel goes to exactly one path
  assign fiq_pending = pending_q & fiq_select;
  assign irq_pending = pending_q & ~fiq_select;

  // low unit has no chain input; its result chains into the high unit
  priority_unit #(
    .BASE          (UNIT1_BASE)
  ) u_unit_low (
    .request       (irq_pending[NUM_CHANNELS-1:UNIT_CHANNELS]),
    .chain_hit     (1'b0),
    .chain_channel (CHANNEL_NONE),
    .hit           (low_hit),
    .channel       (low_channel)
  );

  // high unit resolves channels 0..15 and passes the chained winner otherwise
  priority_unit #(
    .BASE          (UNIT0_BASE)
  ) u_unit_high (
    .request       (irq_pending[UNIT_CHANNELS-1:0]),
    .chain_hit     (low_hit),
    .chain_channel (low_channel),
    .hit           (best_hit),
    .channel       (best_channel)
  );

  // request outputs; the vectored one is held off while the fast one is up
  always_ff @(posedge clock) begin
    if (reset) begin
      fiq_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (enable) begin
      fiq_q <= |fiq_pending;
      irq_q <= (|irq_pending) & ~(|fiq_pending);
    end
  end

  // vector read: winner, its source and its address are captured at the read edge
  always_ff @(posedge clock) begin
    if (reset) begin
      ready_q   <= 1'b0;
      hit_q     <= 1'b0;
      channel_q <= CHANNEL_NONE;
      source_q  <= CHANNEL_NONE;
      addr_q    <= '0;
    end else if (enable) begin
      ready_q <= vector_read;
      if (vector_read) begin
        hit_q     <= best_hit;
        channel_q <= best_hit ? best_channel : CHANNEL_NONE;
        source_q  <= best_hit ? map_arr[best_channel] : CHANNEL_NONE;
        // no winner returns the default so a late read still lands somewhere sane
        addr_q    <= best_hit ? vector_base + VECTOR_STRIDE * VECTOR_W'(best_channel)
                              : default_vector;
      end
    end
  end

  assign fast_interrupt_request = fiq_q;
  assign irq                    = irq_q;
  assign vector_ready           = ready_q;
  assign vector_hit             = hit_q;
  assign vector_channel         = channel_q;
  assign vector_source          = source_q;
  assign vector_addr            = addr_q;

  // helper: mask of channels that outrank the captured winner
  logic [NUM_CHANNELS-1:0] above_mask;
  assign above_mask = (32'h0000_0001 << channel_q) - 32'h0000_0001;

  a_fiq_wins: assert property (@(posedge clock) disable iff (reset)
    fiq_q |-> !irq_q)
    else $error("vectored request raised together with fast request");

  a_irq_or: assert property (@(posedge clock) disable iff (reset)
    enable |=> irq_q == ($past(|irq_pending) && !$past(|fiq_pending)))
    else $error("vectored request not the or of vectored channels");

  a_fiq_route: assert property (@(posedge clock) disable iff (reset)
    enable |=> fiq_q == $past(|(pending_q & fiq_select)))
    else $error("fast request does not follow routed channels");

  a_prio_fixed: assert property (@(posedge clock) disable iff (reset)
    enable && vector_read && (|irq_pending) |=>
      hit_q && (($past(irq_pending) & above_mask) == '0)
            && ((($past(irq_pending) >> channel_q) & 32'h0000_0001) != '0))
    else $error("vector read did not return highest priority channel");

  a_read_answer: assert property (@(posedge clock) disable iff (reset)
    enable && vector_read |=> ready_q ##1 (!ready_q || !enable || $past(vector_read)))
    else $error("vector read answer strobe wrong");

  a_vector_addr: assert property (@(posedge clock) disable iff (reset)
    enable && vector_read && !best_hit |=> !hit_q && addr_q == $past(default_vector))
    else $error("empty read did not return default vector");

  a_force_req: assert property (@(posedge clock) disable iff (reset)
    enable |=> (pending_q & $past(force_request)) == $past(force_request))
    else $error("forced channel not pending");

  a_map_source: assert property (@(posedge clock) disable iff (reset)
    enable && vector_read && best_hit |=> source_q == $past(map_arr[best_channel]))
    else $error("returned source does not match channel map");

  a_wake_all: assert property (@(posedge clock) disable iff (reset)
    enable |=> wake_req_q[WAKE_ALL] == $past((|wake_pins_on) | rtc_irq | usb_resume_irq))
    else $error("wake-all request not the or of wake inputs");

  a_pend_level: assert property (@(posedge clock) disable iff (reset)
    enable && channel_req == '0 |=> pending_q == '0)
    else $error("channel stayed pending after its cause dropped");

  c_fast: cover property (@(posedge clock) disable iff (reset) fiq_q);
  c_vectored: cover property (@(posedge clock) disable iff (reset) irq_q);
  c_read_hit: cover property (@(posedge clock) disable iff (reset) ready_q && hit_q);
  c_both_pending: cover property (@(posedge clock) disable iff (reset)
    (|fiq_pending) && (|irq_pending));

endmodule : vectored_interrupt_controller
`default_nettype wire

// ### verif/core_model.sv
// behavioural core that strobes one vector read per bench request
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic clock,       // bus clock
  input  wire logic reset,       // synchronous, active high
  input  wire logic start,       // bench asks for one read
  output logic      vector_read  // one-cycle read strobe
);
  initial vector_read = 1'b0;
  // launched just after a falling edge so it spans exactly one rising edge
  always @(negedge clock) begin
    vector_read <= !reset && start;
  end
endmodule : core_model
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vic_pkg::*;
  logic                 clock, reset, enable, rtc_irq, usb_resume_irq, start, vector_read;
  logic [26:0]          peripheral_irq;   // on-chip sources 0..26
  logic [29:0]          wake_pin, wake_pin_enable;
  logic [159:0]         channel_map;      // source per channel
  logic [31:0]          force_request, fiq_select, vector_base, default_vector, vector_addr;
  logic                 fast_interrupt_request, irq, vector_ready, vector_hit;
  logic [4:0]           vector_channel, vector_source;
  int                   fails, num_checks;

  vectored_interrupt_controller uut (.clock(clock), .reset(reset), .enable(enable),
    .peripheral_irq(peripheral_irq), .wake_pin(wake_pin), .wake_pin_enable(wake_pin_enable),
    .rtc_irq(rtc_irq), .usb_resume_irq(usb_resume_irq), .channel_map(channel_map),
    .force_request(force_request), .fiq_select(fiq_select), .vector_base(vector_base),
    .default_vector(default_vector), .vector_read(vector_read),
    .fast_interrupt_request(fast_interrupt_request), .irq(irq), .vector_ready(vector_ready),
    .vector_hit(vector_hit), .vector_channel(vector_channel), .vector_source(vector_source),
    .vector_addr(vector_addr));
  core_model core (.clock(clock), .reset(reset), .start(start), .vector_read(vector_read));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic cmp_bit(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %b seen %b", n, e, s);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_word

  // level of one source as the wake-up unit and peripherals present it
  function automatic logic src_on(input logic [4:0] s);
    logic [29:0] p;
    p = wake_pin & wake_pin_enable;
    if (s < 5'h1b) return peripheral_irq[s];
    case (s)
      5'h1b:   return (|p) | rtc_irq | usb_resume_irq;
      5'h1c:   return (|p[5:0]) | rtc_irq | usb_resume_irq;
      5'h1d:   return |p[13:6];
      5'h1e:   return |p[21:14];
      default: return |p[29:22];
    endcase
  endfunction : src_on

  // pending channels: forced or mapped source active, no latching
  function automatic logic [31:0] pend();
    for (int k = 0; k < 32; k++) pend[k] = force_request[k] | src_on(channel_map[5*k +: 5]);
  endfunction : pend

  // settle, compare both requests, then read the vector through the core
  task automatic check_all();
    logic [31:0] p;
    logic [31:0] v;
    logic [4:0]  c;
    int          w;
    p = pend();
    v = p & ~fiq_select;
    c = 5'h00;
    w = 0;
    for (int k = 31; k >= 0; k--) if (v[k]) c = k[4:0];
    repeat (6) @(negedge clock);
    cmp_bit("fast", |(p & fiq_select), fast_interrupt_request);
    cmp_bit("irq", (|v) && !(|(p & fiq_select)), irq);
    start <= 1'b1;
    @(negedge clock);
    start <= 1'b0;
    while (vector_ready !== 1'b1) begin
      @(posedge clock);
      #1;
      w++;
      if (w > 10) begin
        fails++;
        wrap_up();
      end
    end
    cmp_bit("hit", |v, vector_hit);
    cmp_word("channel", {27'h0, c}, {27'h0, vector_channel});
    cmp_word("source", (|v) ? {27'h0, channel_map[5*c +: 5]} : 32'h0, {27'h0, vector_source});
    cmp_word("addr", (|v) ? vector_base + 32'h4 * c : default_vector, vector_addr);
    // hand the next stimulus back on a falling edge
    @(negedge clock);
  endtask : check_all

  initial begin
    #2000000;
    fails++;
    wrap_up();
  end

  initial begin
    {reset, enable, rtc_irq, usb_resume_irq, start} = 5'h18;
    {peripheral_irq, wake_pin, wake_pin_enable, force_request, fiq_select} = '0;
    channel_map = '0;
    vector_base = 32'h0000_1000;
    default_vector = 32'h0000_0ffc;
    fails = 0;
    num_checks = 0;
    repeat (3) @(negedge clock);
    cmp_bit("reset irq", 1'b0, irq);
    cmp_word("reset addr", 32'h0, vector_addr);
    reset = 1'b0;
    void'($urandom(32'h9850));
    for (int k = 0; k < 32; k++) channel_map[5*k +: 5] = k[4:0];
    check_all();
    enable = 1'b0;
    force_request = 32'h0000_0008;
    repeat (6) @(negedge clock);
    cmp_bit("frozen irq", 1'b0, irq);
    enable = 1'b1;
    check_all();
    force_request = 32'h8001_0000;
    check_all();
    fiq_select = 32'h8000_0000;
    check_all();
    // recommended wiring: watchdog, timer zero, transfer engine, bus resume
    fiq_select = 32'h0;
    force_request = 32'h0;
    peripheral_irq = 27'h0001011;
    usb_resume_irq = 1'b1;
    channel_map[5*REC_BUS_RESUME +: 5] = 5'h1b;
    check_all();
    peripheral_irq = 27'h0001010;
    check_all();
    for (int i = 0; i < 40; i++) begin
      channel_map = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
      peripheral_irq = 27'($urandom() & $urandom() & $urandom());
      wake_pin = 30'($urandom() & $urandom());
      wake_pin_enable = 30'($urandom() & $urandom());
      {rtc_irq, usb_resume_irq} = 2'($urandom() & $urandom());
      force_request = $urandom() & $urandom() & $urandom() & $urandom();
      fiq_select = (i % 3 == 0) ? 32'h1 << ($urandom() % 32) : 32'h0;
      vector_base = $urandom() & 32'hffff_ff00;
      check_all();
    end
    {peripheral_irq, wake_pin, force_request, rtc_irq, usb_resume_irq} = '0;
    check_all();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
